// >>> design/host_port.v
`include "host_port_regs.vh"

// Notes on behaviour
// - strap low selects the four-wire spi slave.
// - spi runs up to 40 Mbps; host keeps below that rate.
// - chip select high ignores input and releases the serial output.
// - spi samples on rising clock edge, drives output on falling edge.
// - first spi byte is a command; msb 0 writes, 1 reads.
// - command low seven bits give the start register address.
// - second spi byte is a dummy and its content is ignored.
// - address advances after each data byte while chip select stays low.
// - strap high selects i2c, slave only, never starts transfers.
// - i2c supports standard 100 kbps and fast 400 kbps rates.
// - in i2c, clock pin is scl, output pin sda, cs and din are straps.
// - 7-bit slave address, upper five fixed, low two from straps.
// - register-address byte follows slave address: address plus auto-increment bit.
// - auto-increment writes store successive bytes at rising addresses.
// - current-address read uses the address left by the last access.
// - random read: write register byte, then read one or several locations.
// - four pages; page select at 0x7F on every page steers accesses.
// - page values 00 control, 01 receive, 02 transmit, 03 reserved.
// - page 0 holds control and flag status registers.
// - page 1 presents last received block channel-status and user bits.
// - page 2 is host writable and readable for transmit bits.
// - page 3 refuses access until the private unlock code is given.
// - control page addresses 0x00 and 0x2D to 0x7E are reserved.
module host_port (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       portTypeStrap,
  input  wire       ctrlSerialClock,
  input  wire       chipSel_n,
  input  wire       ctrlSerialIn,
  input  wire       ctrlSerialOutIn,
  output wire       ctrlSerialOut,
  output wire       ctrlSerialOutOe_n,
  output wire [1:0] regPage,
  output wire [6:0] regAddr,
  output wire [7:0] regWdata,
  output wire       regWe,
  output wire       regRe,
  input  wire [7:0] regRdata,
  output wire       testUnlocked
);

  wire modeI2c;
  wire sclSync;
  wire csSync;
  wire dinSync;
  wire sdaSync;

  sync_2ff #(.RESET_VAL(1'b0)) u_syncMode (.clk(clk), .rst_n(rst_n), .din(portTypeStrap),   .dout(modeI2c));
  sync_2ff #(.RESET_VAL(1'b0)) u_syncClk  (.clk(clk), .rst_n(rst_n), .din(ctrlSerialClock), .dout(sclSync));
  sync_2ff #(.RESET_VAL(1'b1)) u_syncCs   (.clk(clk), .rst_n(rst_n), .din(chipSel_n),       .dout(csSync));
  sync_2ff #(.RESET_VAL(1'b0)) u_syncDin  (.clk(clk), .rst_n(rst_n), .din(ctrlSerialIn),    .dout(dinSync));
  sync_2ff #(.RESET_VAL(1'b1)) u_syncSda  (.clk(clk), .rst_n(rst_n), .din(ctrlSerialOutIn), .dout(sdaSync));

  reg       sclPrev_reg;
  reg       sdaPrev_reg;
  reg [1:0] page_reg;
  reg       unlocked_reg;
  reg [6:0] addr_reg;
  reg       readDir_reg;
  reg       autoInc_reg;
  reg [6:0] shiftIn_reg;
  reg [3:0] bitCnt_reg;
  reg [1:0] spiByte_reg;
  reg [2:0] i2cState_reg;
  reg       ackDrive_reg;
  reg [7:0] rdByte_reg;
  reg [7:0] shiftOut_reg;
  reg       outBit_reg;
  reg       outOe_n_reg;
  reg       readPend_reg;
  reg       readCap_reg;
  reg       regWe_reg;
  reg       regRe_reg;
  reg [6:0] regAddr_reg;
  reg [7:0] regWdata_reg;

  wire       sclRise  = sclSync & ~sclPrev_reg;
  wire       sclFall  = ~sclSync & sclPrev_reg;
  wire       spiSel   = ~modeI2c & ~csSync;
  wire [7:0] byteIn   = {shiftIn_reg, modeI2c ? sdaSync : dinSync};
  wire       i2cStart = modeI2c & sclSync & sclPrev_reg & sdaPrev_reg & ~sdaSync;
  wire       i2cStop  = modeI2c & sclSync & sclPrev_reg & ~sdaPrev_reg & sdaSync;
  wire [6:0] slaveAddr = {`I2C_ADDR_FIXED, dinSync, csSync};
  wire       addrMatch = (byteIn[7:1] == slaveAddr);

  // locations that carry no function: reserved control addresses, locked test page
  function blocked;
    input [1:0] pg;
    input [6:0] ad;
    input       unl;
    begin
      blocked = ((pg == `PAGE_CTRL) && ((ad == `CTRL_RSV_LOW) || (ad >= `CTRL_RSV_FIRST)))
             || ((pg == `PAGE_TEST) && !unl);
    end
  endfunction

  wire       curIsSel  = (regAddr_reg == `PAGE_SEL_ADDR);
  wire [7:0] readValue = curIsSel ? {6'h00, page_reg} :
                         (blocked(page_reg, regAddr_reg, unlocked_reg) ? 8'h00 : regRdata);

  // edges and sampled levels
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclPrev_reg <= 1'b0;
      sdaPrev_reg <= 1'b1;
    end
    else
    begin
      sclPrev_reg <= sclSync;
      sdaPrev_reg <= sdaSync;
    end
  end

  // register access pipeline: request, strobe, capture
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRe_reg   <= 1'b0;
      readCap_reg <= 1'b0;
      rdByte_reg  <= 8'h00;
    end
    else
    begin
      regRe_reg   <= readPend_reg && (addr_reg != `PAGE_SEL_ADDR)
                     && !blocked(page_reg, addr_reg, unlocked_reg);
      readCap_reg <= readPend_reg;
      if (readCap_reg)
        rdByte_reg <= readValue;
    end
  end

  // protocol engine
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      page_reg     <= `PAGE_SEL_RESET;
      unlocked_reg <= 1'b0;
      addr_reg     <= 7'h00;
      readDir_reg  <= 1'b0;
      autoInc_reg  <= 1'b0;
      shiftIn_reg  <= 7'h00;
      bitCnt_reg   <= 4'h0;
      spiByte_reg  <= `SPI_BYTE_CMD;
      i2cState_reg <= `I2C_IDLE;
      ackDrive_reg <= 1'b0;
      readPend_reg <= 1'b0;
      regWe_reg    <= 1'b0;
      regAddr_reg  <= 7'h00;
      regWdata_reg <= 8'h00;
    end
    else
    begin
      regWe_reg    <= 1'b0;
      readPend_reg <= 1'b0;
      if (readPend_reg)
        regAddr_reg <= addr_reg;
      if (!modeI2c)
      begin
        i2cState_reg <= `I2C_IDLE;
        ackDrive_reg <= 1'b0;
        if (!spiSel)
        begin
          bitCnt_reg  <= 4'h0;
          spiByte_reg <= `SPI_BYTE_CMD;
        end
        else if (sclRise)
        begin
          shiftIn_reg <= byteIn[6:0];
          bitCnt_reg  <= (bitCnt_reg == `BIT_LAST) ? 4'h0 : bitCnt_reg + 4'h1;
          if (bitCnt_reg == `BIT_LAST)
          begin
            case (spiByte_reg)
              `SPI_BYTE_CMD:
              begin
                readDir_reg <= byteIn[`CMD_DIR_BIT];
                addr_reg    <= byteIn[6:0];
                spiByte_reg <= `SPI_BYTE_DUMMY;
              end
              `SPI_BYTE_DUMMY:
              begin
                readPend_reg <= readDir_reg;
                spiByte_reg  <= `SPI_BYTE_DATA;
              end
              default:
              begin
                addr_reg     <= addr_reg + 7'h01;
                readPend_reg <= readDir_reg;
                if (!readDir_reg)
                begin
                  regWe_reg    <= (addr_reg != `PAGE_SEL_ADDR) && !blocked(page_reg, addr_reg, unlocked_reg);
                  regAddr_reg  <= addr_reg;
                  regWdata_reg <= byteIn;
                  if (addr_reg == `PAGE_SEL_ADDR)
                  begin
                    if (byteIn == `TEST_UNLOCK_CODE)
                      unlocked_reg <= 1'b1;
                    else if ((byteIn[1:0] != `PAGE_TEST) || unlocked_reg)
                      page_reg <= byteIn[1:0];
                  end
                end
              end
            endcase
          end
        end
      end
      else
      begin
        // slave only, timed from sampled scl
        spiByte_reg <= `SPI_BYTE_CMD;
        if (i2cStart)
        begin
          i2cState_reg <= `I2C_ADDR;
          bitCnt_reg   <= 4'h0;
          ackDrive_reg <= 1'b0;
        end
        else if (i2cStop)
        begin
          i2cState_reg <= `I2C_IDLE;
          ackDrive_reg <= 1'b0;
        end
        else if (sclRise && (i2cState_reg != `I2C_IDLE))
        begin
          if (bitCnt_reg == `BIT_ACK)
          begin
            bitCnt_reg   <= 4'h0;
            ackDrive_reg <= 1'b0;
            if ((i2cState_reg == `I2C_RDATA) && !ackDrive_reg) // host ack of a sent byte, not address ack
            begin
              if (autoInc_reg)
                addr_reg <= addr_reg + 7'h01;
              if (sdaSync)
                i2cState_reg <= `I2C_IDLE;
              else
                readPend_reg <= 1'b1;
            end
          end
          else
          begin
            shiftIn_reg <= byteIn[6:0];
            bitCnt_reg  <= bitCnt_reg + 4'h1;
            if (bitCnt_reg == `BIT_LAST)
            begin
              case (i2cState_reg)
                `I2C_ADDR:
                begin
                  ackDrive_reg <= addrMatch;
                  if (!addrMatch)
                    i2cState_reg <= `I2C_IDLE;
                  else if (byteIn[`I2C_RW_BIT])
                  begin
                    i2cState_reg <= `I2C_RDATA;
                    readPend_reg <= 1'b1;
                  end
                  else
                    i2cState_reg <= `I2C_REGADDR;
                end
                `I2C_REGADDR:
                begin
                  ackDrive_reg <= 1'b1;
                  autoInc_reg  <= byteIn[`AUTOINC_BIT];
                  addr_reg     <= byteIn[6:0];
                  i2cState_reg <= `I2C_WDATA;
                end
                `I2C_WDATA:
                begin
                  ackDrive_reg <= 1'b1;
                  if (autoInc_reg)
                    addr_reg <= addr_reg + 7'h01;
                  regWe_reg    <= (addr_reg != `PAGE_SEL_ADDR) && !blocked(page_reg, addr_reg, unlocked_reg);
                  regAddr_reg  <= addr_reg;
                  regWdata_reg <= byteIn;
                  if (addr_reg == `PAGE_SEL_ADDR)
                  begin
                    if (byteIn == `TEST_UNLOCK_CODE)
                      unlocked_reg <= 1'b1;
                    else if ((byteIn[1:0] != `PAGE_TEST) || unlocked_reg)
                      page_reg <= byteIn[1:0];
                  end
                end
                default:
                  ackDrive_reg <= 1'b0;
              endcase
            end
          end
        end
      end
    end
  end

  // output shifter, changes on falling serial clock
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shiftOut_reg <= 8'h00;
      outBit_reg   <= 1'b0;
      outOe_n_reg  <= 1'b1;
    end
    else if (!modeI2c)
    begin
      if (!spiSel)
      begin
        outOe_n_reg <= 1'b1;
        outBit_reg  <= 1'b0;
      end
      else
      begin
        outOe_n_reg <= 1'b0;
        if (sclFall)
        begin
          if ((bitCnt_reg == 4'h0) && (spiByte_reg == `SPI_BYTE_DATA) && readDir_reg)
          begin
            outBit_reg   <= rdByte_reg[7];
            shiftOut_reg <= {rdByte_reg[6:0], 1'b0};
          end
          else
          begin
            outBit_reg   <= shiftOut_reg[7];
            shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
          end
        end
      end
    end
    else
    begin
      outBit_reg <= 1'b0;
      if (i2cStart || i2cStop || (i2cState_reg == `I2C_IDLE))
        outOe_n_reg <= 1'b1;
      else if (sclFall)
      begin
        if (bitCnt_reg == `BIT_ACK)
          outOe_n_reg <= ~ackDrive_reg;
        else if (i2cState_reg == `I2C_RDATA)
        begin
          if (bitCnt_reg == 4'h0)
          begin
            outOe_n_reg  <= rdByte_reg[7];
            shiftOut_reg <= {rdByte_reg[6:0], 1'b0};
          end
          else
          begin
            outOe_n_reg  <= shiftOut_reg[7];
            shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
          end
        end
        else
          outOe_n_reg <= 1'b1;
      end
    end
  end

  assign ctrlSerialOut     = outBit_reg;
  assign ctrlSerialOutOe_n = outOe_n_reg;
  assign regPage           = page_reg;
  assign regAddr           = regAddr_reg;
  assign regWdata          = regWdata_reg;
  assign regWe             = regWe_reg;
  assign regRe             = regRe_reg;
  assign testUnlocked      = unlocked_reg;

endmodule // host_port

// >>> design/host_port_regs.vh
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// register map
`define PAGE_SEL_ADDR      7'h7F
`define CTRL_RSV_LOW       7'h00
`define CTRL_RSV_FIRST     7'h2D
`define PAGE_SEL_RESET     2'h0

// page encoding
`define PAGE_CTRL          2'h0
`define PAGE_RX_BUF        2'h1
`define PAGE_TX_BUF        2'h2
`define PAGE_TEST          2'h3

// test page unlock value written to the page select address (arbitrary)
`define TEST_UNLOCK_CODE   8'hA5

// i2c slave address upper five bits (arbitrary)
`define I2C_ADDR_FIXED     5'h1C

// byte fields
`define CMD_DIR_BIT        7
`define AUTOINC_BIT        7
`define I2C_RW_BIT         0

// serial rates in kbps
`define SPI_MAX_KBPS       40000
`define I2C_STD_KBPS       100
`define I2C_FAST_KBPS      400

// bit counter and spi byte phase values
`define BIT_LAST           4'h7
`define BIT_ACK            4'h8
`define SPI_BYTE_CMD       2'h0
`define SPI_BYTE_DUMMY     2'h1
`define SPI_BYTE_DATA      2'h2

// i2c states
`define I2C_IDLE           3'h0
`define I2C_ADDR           3'h1
`define I2C_REGADDR        3'h2
`define I2C_WDATA          3'h3
`define I2C_RDATA          3'h4

`endif

// >>> design/sync_2ff.v
module sync_2ff #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output wire dout
);

  reg stage1_reg;
  reg stage2_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end

  assign dout = stage2_reg;

endmodule // sync_2ff

// >>> bench/host_port_checker_assertions.sv
module host_port_checker (
  input logic       clk,
  input logic       rst_n,
  input logic       portTypeStrap,
  input logic       chipSel_n,
  input logic       ctrlSerialOut,
  input logic       ctrlSerialOutOe_n,
  input logic [1:0] regPage,
  input logic [6:0] regAddr,
  input logic       regWe,
  input logic       regRe,
  input logic       testUnlocked
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_csIdle;
    (!portTypeStrap && chipSel_n) [*5] |-> ctrlSerialOutOe_n;
  endproperty
  a_csIdle: assert property (p_csIdle)
    else $error("serial out driven while deselected");
  property p_weGap;
    regWe |=> !regWe [*8];
  endproperty
  a_weGap: assert property (p_weGap)
    else $error("write strobes too close");
  property p_reGap;
    regRe |=> !regRe [*8];
  endproperty
  a_reGap: assert property (p_reGap)
    else $error("read strobes too close");
  property p_rsvWrite;
    regWe && regPage == 2'h0 |-> regAddr != 7'h00 && regAddr < 7'h2D;
  endproperty
  a_rsvWrite: assert property (p_rsvWrite)
    else $error("write to reserved control address");
  property p_lockedWrite;
    regWe && regPage == 2'h3 |-> testUnlocked;
  endproperty
  a_lockedWrite: assert property (p_lockedWrite)
    else $error("write to locked test page");
  property p_selInternal;
    regWe || regRe |-> regAddr != 7'h7F;
  endproperty
  a_selInternal: assert property (p_selInternal)
    else $error("page select leaked to register side");
  property p_pageLock;
    $changed(regPage) && regPage == 2'h3 |-> $past(testUnlocked);
  endproperty
  a_pageLock: assert property (p_pageLock)
    else $error("test page entered while locked");
  property p_openDrain;
    portTypeStrap && !ctrlSerialOutOe_n |-> !ctrlSerialOut;
  endproperty
  a_openDrain: assert property (p_openDrain)
    else $error("data line driven high in two-wire mode");
  c_write: cover property (regWe);
  c_read: cover property (regRe);
  c_unlock: cover property ($rose(testUnlocked));
endmodule // host_port_checker

bind host_port host_port_checker chk (
  .clk(clk), .rst_n(rst_n), .portTypeStrap(portTypeStrap), .chipSel_n(chipSel_n),
  .ctrlSerialOut(ctrlSerialOut), .ctrlSerialOutOe_n(ctrlSerialOutOe_n), .regPage(regPage),
  .regAddr(regAddr), .regWe(regWe), .regRe(regRe), .testUnlocked(testUnlocked)
);

// >>> bench/host_model.sv
module host_model (
  input  logic clk,
  input  logic sdaLine,
  output logic sclk,
  output logic csN,
  output logic mosi,
  output logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] dat [4];
  initial
  begin
    sclk = 0;
    csN = 1;
    mosi = 0;
    sda = 1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask
  // mode 0: change on fall, device samples on rise
  task automatic spiByte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      hw(4);
      rx[i] = sdaLine;
      sclk = 1;
      hw(4);
      sclk = 0;
    end
  endtask
  task automatic spi(input logic [7:0] cmd, input int n);
    logic [7:0] junk;
    csN = 0;
    hw(2);
    spiByte(cmd, junk);
    spiByte(8'hFF, junk);
    for (int k = 0; k < n; k++)
      spiByte(dat[k], dat[k]);
    hw(4);
    csN = 1;
    mosi = ~mosi;
    hw(6);
  endtask
  task automatic straps(input logic [1:0] s);
    mosi = s[1];
    csN = s[0];
  endtask
  task automatic i2cStart();
    hw(1);
    sda = 1;
    hw(3);
    sclk = 1;
    hw(4);
    sda = 0;
    hw(4);
    sclk = 0;
  endtask
  task automatic i2cStop();
    hw(1);
    sda = 0;
    hw(3);
    sclk = 1;
    hw(4);
    sda = 1;
    hw(4);
  endtask
  // eight bits plus ack slot; a one in bits releases the line
  task automatic i2cX(input logic [8:0] bits, output logic [8:0] v);
    for (int i = 8; i >= 0; i--)
    begin
      hw(1);
      sda = bits[i];
      hw(3);
      sclk = 1;
      hw(2);
      v[i] = sdaLine;
      hw(2);
      sclk = 0;
    end
  endtask
endmodule // host_model

// >>> bench/host_port_tb_top.sv
`include "host_port_regs.vh"
module host_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 0;
  logic       rst_n = 0;
  logic       strap = 0;
  logic       sclk, csN, mosi, sda, outData, oeN, regWe, regRe, unlocked;
  logic [1:0] page;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] mem [512];
  logic [8:0] v;
  logic [6:0] rsv [3] = '{7'h00, 7'h2D, 7'h7E};
  logic [7:0] aw = {`I2C_ADDR_FIXED, 2'b01, 1'b0};
  int         n_errors = 0;
  int         tests_run = 0;
  wire        sdaLine = (oeN | outData) & sda;
  wire [7:0]  rdata = mem[{page, addr}];
  always #5 clk = ~clk;
  always @(posedge clk)
    if (regWe)
      mem[{page, addr}] <= wdata;
  host_model host (.clk(clk), .sdaLine(sdaLine), .sclk(sclk), .csN(csN), .mosi(mosi), .sda(sda));
  host_port dut (
    .clk(clk), .rst_n(rst_n), .portTypeStrap(strap), .ctrlSerialClock(sclk), .chipSel_n(csN),
    .ctrlSerialIn(mosi), .ctrlSerialOutIn(sdaLine), .ctrlSerialOut(outData), .ctrlSerialOutOe_n(oeN),
    .regPage(page), .regAddr(addr), .regWdata(wdata), .regWe(regWe), .regRe(regRe),
    .regRdata(rdata), .testUnlocked(unlocked)
  );
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.dat[0] = d;
    host.spi({1'b0, a}, 1);
  endtask
  task automatic rd(input logic [6:0] a, input string w, input logic [7:0] e);
    host.spi({1'b1, a}, 1);
    check(w, host.dat[0], e);
  endtask
  task automatic iw(input logic [7:0] b);
    host.i2cX({b, 1'b1}, v);
    check("ack", {7'h00, v[0]}, 8'h00);
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = 8'h00;
    repeat (16) @(negedge clk);
    rst_n = 1;
    repeat (6) @(negedge clk);
    check("unlock", {7'h00, unlocked}, 8'h00);
    rd(`PAGE_SEL_ADDR, "pgsel", 8'h00);
    host.dat = '{8'h12, 8'h34, 8'h56, 8'h00};
    host.spi(8'h05, 3);
    for (int i = 0; i < 3; i++)
      check("autoinc", mem[5 + i], 8'h12 + 8'h22 * i[7:0]);
    host.spi(8'h85, 2);
    check("rd0", host.dat[0], 8'h12);
    check("rd1", host.dat[1], 8'h34);
    wr(7'h2C, 8'h5A);
    check("last", mem[8'h2C], 8'h5A);
    foreach (rsv[k])
    begin
      wr(rsv[k], 8'hEE);
      check("rsvw", mem[rsv[k]], 8'h00);
      rd(rsv[k], "rsvr", 8'h00);
    end
    for (int p = 0; p < 3; p++)
    begin
      wr(`PAGE_SEL_ADDR, p[7:0]);
      check("page", {6'h00, page}, p[7:0]);
      rd(`PAGE_SEL_ADDR, "pgsel", p[7:0]);
      wr(7'h10, 8'h40 + p[7:0]);
      check("pagew", mem[{p[1:0], 7'h10}], 8'h40 + p[7:0]);
      rd(7'h10, "pager", 8'h40 + p[7:0]);
    end
    wr(`PAGE_SEL_ADDR, 8'h03);
    check("locked", {6'h00, page}, 8'h02);
    wr(`PAGE_SEL_ADDR, `TEST_UNLOCK_CODE);
    check("unlock", {7'h00, unlocked}, 8'h01);
    wr(`PAGE_SEL_ADDR, 8'h03);
    check("page3", {6'h00, page}, 8'h03);
    wr(`PAGE_SEL_ADDR, 8'h00);
    host.straps(2'b01);
    strap = 1;
    repeat (8) @(negedge clk);
    host.i2cStart();
    iw(aw);
    iw(8'h85);
    iw(8'hAA);
    iw(8'hBB);
    host.i2cStop();
    check("incw0", mem[5], 8'hAA);
    check("incw1", mem[6], 8'hBB);
    host.i2cStart();
    iw(aw);
    iw(8'h08);
    iw(8'hCC);
    iw(8'hDD);
    host.i2cStop();
    check("same", mem[8], 8'hDD);
    check("next", mem[9], 8'h00);
    host.i2cStart();
    iw(aw | 8'h01);
    host.i2cX(9'h1FF, v);
    host.i2cStop();
    check("curr", v[8:1], 8'hDD);
    host.i2cStart();
    iw(aw);
    iw(8'h85);
    host.i2cStart();
    iw(aw | 8'h01);
    host.i2cX(9'h1FE, v);
    check("rand0", v[8:1], 8'hAA);
    host.i2cX(9'h1FF, v);
    check("rand1", v[8:1], 8'hBB);
    host.i2cStop();
    host.i2cStart();
    host.i2cX({aw ^ 8'h06, 1'b1}, v);
    check("nack", {7'h00, v[0]}, 8'h01);
    host.i2cStop();
    final_report();
  end
endmodule // host_port_tb_top
